// File: core/msc_ctrl.sv
// Purpose: eight-bit system control register behind an axi4-lite slave
// Assumes: cpu interrupt mask, power-on and stop entry arrive as aclk-domain levels
// Notes: drives pulse outputs, bus divider select, watchdog and interrupt request
`timescale 1ns/10ps

module msc_ctrl #(
  parameter logic WATCHDOG_KICK_ENABLE_OPTION = 1'b0, // mask option: watchdog enabled after reset
  parameter int WATCHDOG_KICK_ENABLE_W = 16 // watchdog counter width
) (
  input wire logic aclk, // bus clock, 250 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic power_on, // high for the power-on reset cycles
  input wire logic stop_entry, // one-cycle pulse on stop mode entry
  input wire logic cpu_irq_mask, // cpu interrupt mask bit
  input wire logic timer_tick, // one-cycle timer clock enable
  input wire logic [7:0] pwm_a_value, // pulse length a, written by software
  input wire logic [7:0] pwm_b_value, // pulse length b, written by software
  input wire logic irq_pin_n, // external interrupt pin
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output msc_pkg::msc_ctrl_type ctrl, // control bits to the rest of the chip
  output logic pulse_output_a, // pulse length output a
  output logic pulse_output_b, // pulse length output b
  output logic bus_clk_en, // one pulse per bus cycle of the divided clock
  output logic ext_irq_req, // external interrupt request to the cpu
  output logic watchdog_kick_enable_reset // watchdog timeout pulse
);
  import msc_pkg::*;

  localparam int BUS_DIV_W = $clog2(MSC_BUS_DIV_SLOW);
  localparam int PWM_W = $clog2(MSC_PWM_SLOW_PERIOD);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic por_flag_r; // power-on seen
  logic rise_sel_r; // sensitivity rising bit
  logic fall_sel_r; // sensitivity falling bit
  logic irq_en_r; // external interrupt enable
  logic pwm_a_slow_r; // output a long period
  logic pwm_b_slow_r; // output b long period
  logic slow_mode_r; // bus slow mode
  logic watchdog_kick_enable_en_r; // watchdog running
  logic [WATCHDOG_KICK_ENABLE_W-1:0] watchdog_kick_enable_cnt_r; // watchdog down counter
  logic [WATCHDOG_KICK_ENABLE_W-1:0] watchdog_kick_enable_preset_r; // reload value
  logic [7:0] ctrl_byte; // readback view

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel, address and data taken in either order
  logic aw_held_r; // write address captured
  logic w_held_r; // write data captured
  logic [11:0] aw_addr_r; // captured write address
  logic [31:0] w_data_r; // captured write data
  logic [3:0] w_strb_r; // captured strobes
  logic bvalid_r; // response pending
  logic [1:0] bresp_r; // response code
  logic wr_go; // both halves present, commit now

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // capture write address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write decode, the commit happens in the same cycle that both halves are held
  logic ctrl_wr; // control byte written this cycle
  logic preset_wr; // watchdog preset written
  logic [7:0] wbyte; // low data byte
  assign wbyte = w_data_r[7:0];
  assign ctrl_wr = wr_go && (aw_addr_r[11:2] == MSC_CTRL_OFFSET[11:2]) && w_strb_r[0];
  assign preset_wr = wr_go && (aw_addr_r[11:2] == MSC_WATCHDOG_KICK_ENABLE_OFFSET[11:2]);

  // write response, unmapped addresses get slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= MSC_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= ((aw_addr_r[11:2] == MSC_CTRL_OFFSET[11:2]) || preset_wr) ?
                   MSC_RESP_OKAY : MSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel, one read at a time
  logic rvalid_r; // read data pending
  logic [31:0] rdata_r; // read data
  logic [1:0] rresp_r; // read response
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // read mux, control register upper bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= MSC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rresp_r <= MSC_RESP_OKAY;
        if (s_axi_araddr[11:2] == MSC_CTRL_OFFSET[11:2]) begin
          rdata_r <= {24'h00_0000, ctrl_byte};
        end else if (s_axi_araddr[11:2] == MSC_WATCHDOG_KICK_ENABLE_OFFSET[11:2]) begin
          rdata_r <= 32'({watchdog_kick_enable_cnt_r, watchdog_kick_enable_preset_r});
        end else begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= MSC_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on flag, set wins over a software clear
  // power-on arrives while reset is still held, so reset loads the source level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_flag_r <= power_on;
    end else if (clk_en) begin
      if (power_on) begin
        por_flag_r <= 1'b1;
      end else if (ctrl_wr && !wbyte[MSC_POR_BIT]) begin
        por_flag_r <= 1'b0;
      end
    end
  end

  // interrupt configuration, locked unless the cpu mask is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_sel_r <= 1'b0;
      fall_sel_r <= 1'b0;
      irq_en_r <= MSC_IRQEN_RST;
    end else if (clk_en && ctrl_wr && cpu_irq_mask) begin
      rise_sel_r <= wbyte[MSC_RISE_BIT];
      fall_sel_r <= wbyte[MSC_FALL_BIT];
      irq_en_r <= wbyte[MSC_IRQEN_BIT];
    end
  end

  // speed selects take effect at once, no shadow copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_a_slow_r <= 1'b0;
      pwm_b_slow_r <= 1'b0;
    end else if (clk_en && ctrl_wr) begin
      pwm_a_slow_r <= wbyte[MSC_PWMA_BIT];
      pwm_b_slow_r <= wbyte[MSC_PWMB_BIT];
    end
  end

  // slow mode, stop entry clears and beats a same-cycle write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_mode_r <= 1'b0;
    end else if (clk_en) begin
      if (stop_entry) begin
        slow_mode_r <= 1'b0;
      end else if (ctrl_wr) begin
        slow_mode_r <= wbyte[MSC_SLOW_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, software can only set the enable, expiry reloads it from the option, and a one reloads the counter
  logic watchdog_kick_enable_kick; // software service write
  logic watchdog_kick_enable_expire; // counter reached zero
  assign watchdog_kick_enable_kick = ctrl_wr && wbyte[MSC_WATCHDOG_KICK_ENABLE_BIT];
  assign watchdog_kick_enable_expire = watchdog_kick_enable_en_r && (watchdog_kick_enable_cnt_r == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_kick_enable_en_r <= WATCHDOG_KICK_ENABLE_OPTION;
    end else if (clk_en) begin
      if (watchdog_kick_enable_expire) begin
        watchdog_kick_enable_en_r <= WATCHDOG_KICK_ENABLE_OPTION;
      end else if (watchdog_kick_enable_kick) begin
        watchdog_kick_enable_en_r <= 1'b1;
      end
      // a zero write leaves the enable alone
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_kick_enable_preset_r <= MSC_WATCHDOG_KICK_ENABLE_PRESET_RST[WATCHDOG_KICK_ENABLE_W-1:0];
    end else if (clk_en && preset_wr && !watchdog_kick_enable_en_r) begin
      watchdog_kick_enable_preset_r <= w_data_r[WATCHDOG_KICK_ENABLE_W-1:0]; // locked once running
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_kick_enable_cnt_r <= MSC_WATCHDOG_KICK_ENABLE_PRESET_RST[WATCHDOG_KICK_ENABLE_W-1:0];
    end else if (clk_en) begin
      if (watchdog_kick_enable_kick || watchdog_kick_enable_expire || !watchdog_kick_enable_en_r) begin
        watchdog_kick_enable_cnt_r <= watchdog_kick_enable_preset_r;
      end else if (timer_tick) begin
        watchdog_kick_enable_cnt_r <= watchdog_kick_enable_cnt_r - 1'b1;
      end
    end
  end

  assign watchdog_kick_enable_reset = watchdog_kick_enable_expire;

  ////////////////////////////////////////////////////////////////////////////
  // bus clock divider, osc/2 fast and osc/32 slow, aclk stands for osc/2
  logic [BUS_DIV_W-1:0] div_cnt_r; // divider phase
  logic [BUS_DIV_W-1:0] div_last; // terminal count
  assign div_last = slow_mode_r ?
                    BUS_DIV_W'(MSC_BUS_DIV_SLOW / MSC_BUS_DIV_FAST - 1) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= '0;
    end else if (clk_en) begin
      div_cnt_r <= (div_cnt_r >= div_last) ? '0 : div_cnt_r + 1'b1;
    end
  end
  assign bus_clk_en = clk_en && (div_cnt_r >= div_last);

  ////////////////////////////////////////////////////////////////////////////
  // pulse outputs, 8-bit duty stretched over the chosen period
  logic [PWM_W-1:0] pwm_cnt_r; // shared timer tick counter
  logic pwm_a_r; // output a flop
  logic pwm_b_r; // output b flop
  logic [PWM_W-1:0] pwm_a_lim; // high time in ticks
  logic [PWM_W-1:0] pwm_b_lim;
  logic [PWM_W-1:0] fast_cnt; // count folded to the short period
  localparam int SLOW_SHIFT = PWM_W - $clog2(MSC_PWM_FAST_PERIOD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt_r <= '0;
    end else if (clk_en && timer_tick) begin
      pwm_cnt_r <= pwm_cnt_r + 1'b1; // wraps at the slow period
    end
  end

  assign fast_cnt = {{SLOW_SHIFT{1'b0}}, pwm_cnt_r[PWM_W-SLOW_SHIFT-1:0]};
  assign pwm_a_lim = pwm_a_slow_r ? PWM_W'({pwm_a_value, {SLOW_SHIFT{1'b0}}}) :
                     PWM_W'(pwm_a_value);
  assign pwm_b_lim = pwm_b_slow_r ? PWM_W'({pwm_b_value, {SLOW_SHIFT{1'b0}}}) :
                     PWM_W'(pwm_b_value);

  // speed bits are not buffered; changing them mid-period can glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_a_r <= 1'b0;
      pwm_b_r <= 1'b0;
    end else if (clk_en) begin
      pwm_a_r <= (pwm_a_slow_r ? pwm_cnt_r : fast_cnt) < pwm_a_lim;
      pwm_b_r <= (pwm_b_slow_r ? pwm_cnt_r : fast_cnt) < pwm_b_lim;
    end
  end
  assign pulse_output_a = pwm_a_r;
  assign pulse_output_b = pwm_b_r;

  ////////////////////////////////////////////////////////////////////////////
  // external interrupt path
  logic pin_event; // selected sensitivity hit
  msc_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin_in(irq_pin_n),
    .sense(msc_sense_type'({rise_sel_r, fall_sel_r})),
    .event_out(pin_event)
  );
  assign ext_irq_req = irq_en_r && pin_event;

  ////////////////////////////////////////////////////////////////////////////
  // readback and exported controls
  assign ctrl_byte = {por_flag_r, rise_sel_r, fall_sel_r, irq_en_r,
                      pwm_a_slow_r, pwm_b_slow_r, slow_mode_r, watchdog_kick_enable_en_r};
  assign ctrl = '{ext_irq_enable: irq_en_r, irq_rise_select: rise_sel_r,
                  irq_fall_select: fall_sel_r, pwm_a_slow_select: pwm_a_slow_r,
                  pwm_b_slow_select: pwm_b_slow_r, bus_slow_mode: slow_mode_r};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_por_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && power_on |=> por_flag_r) else $error("power-on flag not set");
  chk_por_no_set: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !power_on && !por_flag_r |=> !por_flag_r) else $error("flag set by software");
  chk_sense_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && !cpu_irq_mask |=> $stable({rise_sel_r, fall_sel_r, irq_en_r}))
    else $error("irq config changed while unmasked");
  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !irq_en_r |-> !ext_irq_req) else $error("irq passed while disabled");
  chk_slow_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && stop_entry |=> !slow_mode_r) else $error("slow mode kept over stop");
  chk_slow_div: assert property (@(posedge aclk) disable iff (!aresetn)
    slow_mode_r && clk_en && bus_clk_en ##1 (slow_mode_r && clk_en)[*8] |-> !bus_clk_en)
    else $error("slow bus pulse too early");
  chk_watchdog_kick_enable_kick: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && watchdog_kick_enable_kick && !watchdog_kick_enable_expire |=> watchdog_kick_enable_en_r && watchdog_kick_enable_cnt_r == $past(watchdog_kick_enable_preset_r))
    else $error("watchdog kick not applied");
  chk_watchdog_kick_enable_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_kick_enable_en_r && !watchdog_kick_enable_expire |=> watchdog_kick_enable_en_r) else $error("watchdog disabled");
  chk_pwm_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !pwm_a_slow_r && $past(!pwm_a_slow_r) && pwm_a_value == 8'h00 |=> !pwm_a_r)
    else $error("output a high at zero duty");
  cov_por_clear: cover property (@(posedge aclk) por_flag_r ##1 !por_flag_r);
  cov_watchdog_kick_enable_on: cover property (@(posedge aclk) !watchdog_kick_enable_en_r ##1 watchdog_kick_enable_en_r);
  cov_irq: cover property (@(posedge aclk) ext_irq_req);
  cov_slow: cover property (@(posedge aclk) slow_mode_r && bus_clk_en);

endmodule : msc_ctrl

// File: shared/msc_pkg.sv
// Purpose: constants and carrier types for the system control register block
// Assumes: one 32-bit axi4-lite slave, one clock, synchronous active-low reset
// Notes: register layout is eight bits in the low byte of one word
package msc_pkg;

  // register map
  localparam logic [11:0] MSC_CTRL_OFFSET = 12'h00c; // system control register byte address
  localparam logic [11:0] MSC_WATCHDOG_KICK_ENABLE_OFFSET = 12'h010; // watchdog preset and counter readback

  // field positions inside the control byte
  localparam int MSC_POR_BIT = 7;
  localparam int MSC_RISE_BIT = 6;
  localparam int MSC_FALL_BIT = 5;
  localparam int MSC_IRQEN_BIT = 4;
  localparam int MSC_PWMA_BIT = 3;
  localparam int MSC_PWMB_BIT = 2;
  localparam int MSC_SLOW_BIT = 1;
  localparam int MSC_WATCHDOG_KICK_ENABLE_BIT = 0;

  // values after reset
  localparam logic MSC_IRQEN_RST = 1'b1; // external interrupt enabled after reset
  localparam logic [15:0] MSC_WATCHDOG_KICK_ENABLE_PRESET_RST = 16'hffff; // default watchdog reload value

  // pulse output periods in timer clock periods
  localparam int MSC_PWM_FAST_PERIOD = 256;
  localparam int MSC_PWM_SLOW_PERIOD = 4096;

  // bus clock divide ratios from the oscillator
  localparam int MSC_BUS_DIV_FAST = 2;
  localparam int MSC_BUS_DIV_SLOW = 32;

  // axi responses
  localparam logic [1:0] MSC_RESP_OKAY = 2'b00;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'b10;

  // sensitivity codes {rise, fall}
  typedef enum logic [1:0] {
    MSC_SENSE_FALL_LEVEL = 2'b00,
    MSC_SENSE_FALL = 2'b01,
    MSC_SENSE_RISE = 2'b10,
    MSC_SENSE_BOTH = 2'b11
  } msc_sense_type;

  // control bits seen by the rest of the chip
  typedef struct packed {
    logic ext_irq_enable; // interrupt pin function on
    logic irq_rise_select; // rising edge sensitivity
    logic irq_fall_select; // falling edge sensitivity
    logic pwm_a_slow_select; // long period for output a
    logic pwm_b_slow_select; // long period for output b
    logic bus_slow_mode; // bus runs at osc/32
  } msc_ctrl_type;

endpackage : msc_pkg

// File: core/msc_edge_detect.sv
// Purpose: synchronise the interrupt pin and flag the selected sensitivity
// Assumes: pin is asynchronous to aclk; clock enable freezes all state
// Notes: a change counts once the second and third stage agree
`timescale 1ns/10ps
module msc_edge_detect (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic clk_en, // state frozen while low
  input wire logic pin_in, // raw interrupt pin, active low level
  input wire msc_pkg::msc_sense_type sense, // selected sensitivity
  output logic event_out // one-cycle request pulse, or level while low
);
  import msc_pkg::*;

  logic [2:0] sync_r; // three-stage synchroniser
  logic stable_r; // filtered pin value
  logic stable_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser, stage 0 is read only by stage 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_r <= 3'h7; // idle high pin
    end else if (clk_en) begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // accept a change only when stages two and three agree
  always_comb begin
    stable_nxt = stable_r;
    if (sync_r[1] == sync_r[2]) begin
      stable_nxt = sync_r[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_r <= 1'b1;
    end else if (clk_en) begin
      stable_r <= stable_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sensitivity decode, edges are pulses and the low level stays asserted
  always_comb begin
    logic fell;
    logic rose;
    fell = stable_r & ~stable_nxt;
    rose = ~stable_r & stable_nxt;
    unique case (sense)
      MSC_SENSE_FALL_LEVEL: event_out = fell | ~stable_r;
      MSC_SENSE_FALL: event_out = fell;
      MSC_SENSE_RISE: event_out = rose;
      MSC_SENSE_BOTH: event_out = fell | rose;
    endcase
  end

endmodule : msc_edge_detect

// File: dv/msc_cpu_model.sv
// Purpose: cpu side axi4-lite master
// Assumes: one write and one read at a time
// Notes: bench calls wr and rd
`timescale 1ns/10ps
module msc_cpu_model (
  input wire logic aclk, // clock
  output logic [11:0] s_axi_awaddr, // aw addr
  output logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  output logic [31:0] s_axi_wdata, // w data
  output logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  output logic s_axi_bready, // b ready
  output logic [11:0] s_axi_araddr, // ar addr
  output logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  output logic s_axi_rready // r ready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  //////////////////////////////////////////
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready && !ta) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !tw) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  // rready held from the request until data is seen
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : msc_cpu_model

// File: dv/tb.sv
// Purpose: self-checking bench for the control register
// Assumes: bus results checked from queues by a monitor
// Notes: pulse speeds, sense codes, slow mode, watchdog
`timescale 1ns/10ps
module tb;
  import msc_pkg::*;
  localparam logic [11:0] CT = MSC_CTRL_OFFSET;
  localparam logic [1:0] OK = MSC_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn, power_on, stop_entry, cpu_irq_mask, timer_tick, irq_pin_n;
  logic [7:0] pwm_a_value, pwm_b_value;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  msc_ctrl_type ctrl;
  logic pulse_output_a, pulse_output_b, bus_clk_en, ext_irq_req, watchdog_kick_enable_reset;
  logic [33:0] exp_r[$]; // {resp, data} of reads
  logic [1:0] exp_b[$]; // write responses
  int err_count = 0;
  int num_checks = 0;
  int wd_cnt = 0; // expiry pulses seen
  always #2 aclk = ~aclk;
  msc_ctrl #(.WATCHDOG_KICK_ENABLE_OPTION(1'b0), .WATCHDOG_KICK_ENABLE_W(16)) DUT (
    .aclk, .aresetn, .clk_en(1'b1), .power_on, .stop_entry, .cpu_irq_mask, .timer_tick,
    .pwm_a_value, .pwm_b_value, .irq_pin_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl, .pulse_output_a,
    .pulse_output_b, .bus_clk_en, .ext_irq_req, .watchdog_kick_enable_reset
  );
  msc_cpu_model u_cpu (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready
  );
  //////////////////////////////////////////
  function automatic logic [31:0] lfsr_nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_nxt
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    u_cpu.wr(a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    u_cpu.rd(a);
  endtask : rd
  // control write then read back
  task automatic wrr(input logic [31:0] d, input logic [31:0] e);
    wr(CT, d, OK);
    rd(CT, e, OK);
  endtask : wrr
  // counts bus enables, or request rises when edg is set
  task automatic cnt(input int n, input bit edg, output int c);
    logic prv;
    c = 0;
    prv = ext_irq_req;
    repeat (n) begin
      @(posedge aclk);
      c += edg ? int'(ext_irq_req && !prv) : int'(bus_clk_en);
      prv = ext_irq_req;
    end
  endtask : cnt
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      timer_tick <= 1'b1;
      @(posedge aclk);
      timer_tick <= 1'b0;
    end
  endtask : tick
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////
  // monitor: oldest note against each bus result
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if ((s_axi_bvalid && s_axi_bready) === 1'b1)
      check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
    if (watchdog_kick_enable_reset === 1'b1)
      wd_cnt++;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    complete_run();
  end
  initial begin
    int c, ca, cb;
    logic [1:0] cd;
    logic ie;
    aresetn = 1'b0;
    power_on = 1'b1;
    {stop_entry, cpu_irq_mask, timer_tick, pwm_a_value, pwm_b_value} = '0;
    irq_pin_n = 1'b1;
    lfsr = 32'h0001_6842;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    power_on <= 1'b0;
    rd(CT, 32'h0000_0090, OK);
    // mask low: sense and enable bits hold, flag only clears
    wrr(32'h0000_00e0, 32'h0000_0090);
    wrr(32'h0000_0000, 32'h0000_0010);
    wrr(32'h0000_0080, 32'h0000_0010);
    wrr(32'h0000_0002, 32'h0000_0012);
    cnt(64, 1'b0, c);
    check(34'(c), 34'h4);
    stop_entry <= 1'b1;
    @(posedge aclk);
    stop_entry <= 1'b0;
    rd(CT, 32'h0000_0010, OK);
    cnt(64, 1'b0, c);
    check(34'(c), 34'h40);
    // speed bits first, then random lengths; one period window
    for (int k = 0; k < 2; k++) begin
      wrr(k ? 32'h0000_0008 : 32'h0000_0004, k ? 32'h0000_0018 : 32'h0000_0014);
      lfsr = lfsr_nxt(lfsr);
      pwm_a_value <= lfsr[7:0];
      pwm_b_value <= lfsr[15:8];
      timer_tick <= 1'b1;
      repeat (4096) @(posedge aclk);
      ca = 0;
      cb = 0;
      for (int i = 0; i < 4096; i++) begin
        @(posedge aclk);
        ca += (i < (k ? 4096 : 256)) ? int'(pulse_output_a) : 0;
        cb += (i < (k ? 256 : 4096)) ? int'(pulse_output_b) : 0;
      end
      check(34'(ca), 34'(pwm_a_value) << (k ? 4 : 0));
      check(34'(cb), 34'(pwm_b_value) << (k ? 0 : 4));
    end
    timer_tick <= 1'b0;
    cpu_irq_mask <= 1'b1;
    // every sense code, then enable off
    for (int k = 0; k < 5; k++) begin
      cd = 2'(k);
      ie = (k < 4);
      wrr(32'({cd, ie, 4'h0}), 32'({cd, ie, 4'h0}));
      check(34'(ctrl), 34'({ie, cd, 3'b000}));
      irq_pin_n <= 1'b0;
      cnt(12, 1'b1, c);
      check(34'(c), 34'(ie && cd != 2'b10));
      irq_pin_n <= 1'b1;
      cnt(12, 1'b1, c);
      check(34'(c), 34'(ie && cd[1]));
    end
    cpu_irq_mask <= 1'b0;
    wr(MSC_WATCHDOG_KICK_ENABLE_OFFSET, 32'h0000_0008, OK);
    tick(20);
    check(34'(wd_cnt), 34'h0);
    wrr(32'h0000_0001, 32'h0000_0001);
    wrr(32'h0000_0000, 32'h0000_0001);
    tick(6);
    wrr(32'h0000_0001, 32'h0000_0001);
    tick(6);
    check(34'(wd_cnt), 34'h0);
    tick(12);
    check(34'(wd_cnt), 34'h1);
    rd(CT, 32'h0000_0000, OK);
    wr(12'h020, 32'hffff_ffff, MSC_RESP_SLVERR);
    rd(12'h020, 32'h0000_0000, MSC_RESP_SLVERR);
    wr(CT, 32'h0000_0002, OK);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CT, 32'h0000_0010, OK);
    repeat (4) @(posedge aclk);
    complete_run();
  end
endmodule : tb
